// *** design/dali_consts.vh ***
/*
 * Shared constants for the debug-unit APB link pair: port widths and the
 * reset levels of the control outputs.
 * Assumes it is included by bare name from files under design/.
 */
`ifndef DALI_CONSTS_VH
`define DALI_CONSTS_VH

// ----------------------------------------------------------------------
// inbound link (cluster master -> debug unit slave)
// ----------------------------------------------------------------------
`define DALI_IN_ADDR_MSB    8
`define DALI_IN_ADDR_LSB    2
`define DALI_IN_DATA_MSB    8

// ----------------------------------------------------------------------
// outbound link (debug unit master -> cluster slave)
// ----------------------------------------------------------------------
`define DALI_OUT_ADDR_MSB   19
`define DALI_OUT_ADDR_LSB   2
`define DALI_OUT_DATA_MSB   31

// ----------------------------------------------------------------------
// reset levels
// ----------------------------------------------------------------------
`define DALI_CTRL_RST       1'h0
`define DALI_CHECK_RST      1'h1
`define DALI_IN_ADDR_RST    7'h00
`define DALI_IN_DATA_RST    9'h000
`define DALI_OUT_ADDR_RST   18'h00000
`define DALI_OUT_DATA_RST   32'h00000000

`endif

// *** design/dali_link.v ***
/*
 * Both APB links of the debug unit: the slave port driven by the cluster
 * master, with inverted-copy check outputs, and the master port driving the
 * cluster slave, with inverted-copy and odd-parity check outputs.
 * Assumes both links, the power controller handshake and the internal
 * request side all run on the one debug APB clock, so no input is
 * synchronised.
 */
// Function
// - Every single-bit check output is the inverse of its companion signal.
// - The master port drives per-bit odd parity over address[19:2], the write indicator and write data[31:0].
// - The master port direction output is high for a write and low for a read.
// - The slave port holds ready low until the internal side completes or the access is refused after power-down, with ready_check tracking it.
// - While the cluster slave holds ready low the master port keeps select, enable, address and data stable.
// - A failed transfer shows error in the completing cycle, driven on the slave port and sampled on the master port.
// - The link is two independent APB connections, one per direction, each signal matching its namesake.
// - After the power-down request is accepted every later slave-port access completes with error.
`include "dali_consts.vh"

module dali_link (
    // clock and reset
    input  wire                           clock,
    input  wire                           rst,
    // inbound link from the cluster master
    input  wire                           in_port_select,
    input  wire [`DALI_IN_ADDR_MSB:`DALI_IN_ADDR_LSB] in_port_word_address,
    input  wire                           in_port_enable,
    input  wire [`DALI_IN_DATA_MSB:0]     in_port_write_data,
    input  wire                           in_port_activity,
    output reg                            in_port_ready,
    output reg                            in_port_ready_check,
    output reg                            in_port_error,
    output reg                            in_port_error_check,
    // internal side of the inbound link
    output reg                            in_req_valid,
    output reg  [`DALI_IN_ADDR_MSB:`DALI_IN_ADDR_LSB] in_req_address,
    output reg  [`DALI_IN_DATA_MSB:0]     in_req_write_data,
    output reg                            in_link_active,
    input  wire                           in_resp_done,
    input  wire                           in_resp_error,
    // power controller
    input  wire                           power_down_accepted,
    // outbound link to the cluster slave
    output reg                            out_port_select,
    output reg                            out_port_select_check,
    output reg  [`DALI_OUT_ADDR_MSB:`DALI_OUT_ADDR_LSB] out_port_word_address,
    output reg  [`DALI_OUT_ADDR_MSB:`DALI_OUT_ADDR_LSB] out_port_address_parity,
    output reg                            out_port_enable,
    output reg                            out_port_enable_check,
    output reg                            out_port_direction,
    output reg                            out_port_direction_parity,
    output reg  [`DALI_OUT_DATA_MSB:0]    out_port_write_data,
    output reg  [`DALI_OUT_DATA_MSB:0]    out_port_write_data_parity,
    output reg                            out_port_activity,
    output reg                            out_port_activity_check,
    input  wire                           out_port_ready,
    input  wire [`DALI_OUT_DATA_MSB:0]    out_port_read_data,
    input  wire                           out_port_error,
    // internal command side of the outbound link
    input  wire                           cmd_valid,
    input  wire                           cmd_write,
    input  wire [`DALI_OUT_ADDR_MSB:`DALI_OUT_ADDR_LSB] cmd_address,
    input  wire [`DALI_OUT_DATA_MSB:0]    cmd_write_data,
    output reg                            cmd_ready,
    output reg                            cmd_done,
    output reg                            cmd_error,
    output reg  [`DALI_OUT_DATA_MSB:0]    cmd_read_data
);

    // ------------------------------------------------------------------
    // state codes
    // ------------------------------------------------------------------
    localparam [2:0] SL_IDLE   = 3'h1;
    localparam [2:0] SL_WAIT   = 3'h2;
    localparam [2:0] SL_DONE   = 3'h4;
    localparam [2:0] MS_IDLE   = 3'h1;
    localparam [2:0] MS_SETUP  = 3'h2;
    localparam [2:0] MS_ACCESS = 3'h4;

    // ------------------------------------------------------------------
    // odd parity of one bit is its inverse, so a vector's per-bit
    // parity is the bitwise inverse
    // ------------------------------------------------------------------
    function [31:0] odd_par32;
        input [31:0] v;
        begin
            odd_par32 = ~v;
        end
    endfunction

    reg  [2:0] sl_state_q;
    reg        pd_seen_q;
    reg  [2:0] ms_state_q;

    wire in_setup = in_port_select & ~in_port_enable;
    wire ms_take  = (ms_state_q == MS_IDLE) & cmd_ready & cmd_valid;
    wire [31:0] addr_par = odd_par32({14'h0000, cmd_address});

    // ------------------------------------------------------------------
    // power-down latch
    // ------------------------------------------------------------------
    // sticky until reset: the debug unit is not expected to come back
    // without one
    always @(posedge clock) begin
        if (rst) begin
            pd_seen_q <= 1'h0;
        end else if (power_down_accepted) begin
            pd_seen_q <= 1'h1;
        end
    end

    // ------------------------------------------------------------------
    // inbound slave port
    // ------------------------------------------------------------------
    always @(posedge clock) begin
        if (rst) begin
            sl_state_q          <= SL_IDLE;
            in_port_ready       <= `DALI_CTRL_RST;
            in_port_ready_check <= `DALI_CHECK_RST;
            in_port_error       <= `DALI_CTRL_RST;
            in_port_error_check <= `DALI_CHECK_RST;
            in_req_valid        <= 1'h0;
            in_req_address      <= `DALI_IN_ADDR_RST;
            in_req_write_data   <= `DALI_IN_DATA_RST;
            in_link_active      <= 1'h0;
        end else begin
            in_req_valid   <= 1'h0;
            in_link_active <= in_port_activity;
            case (sl_state_q)
                SL_IDLE: begin
                    if (in_setup) begin
                        in_req_address    <= in_port_word_address;
                        in_req_write_data <= in_port_write_data;
                        if (pd_seen_q | power_down_accepted) begin
                            // refused outright; no request pulse, though address and data are still latched
                            sl_state_q          <= SL_DONE;
                            in_port_ready       <= 1'h1;
                            in_port_ready_check <= 1'h0;
                            in_port_error       <= 1'h1;
                            in_port_error_check <= 1'h0;
                        end else begin
                            sl_state_q   <= SL_WAIT;
                            in_req_valid <= 1'h1;
                        end
                    end
                end
                SL_WAIT: begin
                    // ready stays low, stretching the access phase
                    if (in_resp_done) begin
                        sl_state_q          <= SL_DONE;
                        in_port_ready       <= 1'h1;
                        in_port_ready_check <= 1'h0;
                        in_port_error       <= in_resp_error;
                        in_port_error_check <= ~in_resp_error;
                    end
                end
                SL_DONE: begin
                    // completing cycle seen; drop ready and error together
                    sl_state_q          <= SL_IDLE;
                    in_port_ready       <= 1'h0;
                    in_port_ready_check <= 1'h1;
                    in_port_error       <= 1'h0;
                    in_port_error_check <= 1'h1;
                end
                default: begin
                    sl_state_q          <= SL_IDLE;
                    in_port_ready       <= 1'h0;
                    in_port_ready_check <= 1'h1;
                    in_port_error       <= 1'h0;
                    in_port_error_check <= 1'h1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // outbound master port
    // ------------------------------------------------------------------
    always @(posedge clock) begin
        if (rst) begin
            ms_state_q                 <= MS_IDLE;
            out_port_select            <= `DALI_CTRL_RST;
            out_port_select_check      <= `DALI_CHECK_RST;
            out_port_enable            <= `DALI_CTRL_RST;
            out_port_enable_check      <= `DALI_CHECK_RST;
            out_port_activity          <= `DALI_CTRL_RST;
            out_port_activity_check    <= `DALI_CHECK_RST;
            out_port_direction         <= `DALI_CTRL_RST;
            out_port_direction_parity  <= `DALI_CHECK_RST;
            out_port_word_address      <= `DALI_OUT_ADDR_RST;
            out_port_address_parity    <= ~`DALI_OUT_ADDR_RST;
            out_port_write_data        <= `DALI_OUT_DATA_RST;
            out_port_write_data_parity <= ~`DALI_OUT_DATA_RST;
            cmd_ready                  <= 1'h0;
            cmd_done                   <= 1'h0;
            cmd_error                  <= 1'h0;
            cmd_read_data              <= `DALI_OUT_DATA_RST;
        end else begin
            cmd_done <= 1'h0;
            case (ms_state_q)
                MS_IDLE: begin
                    cmd_ready <= 1'h1;
                    if (ms_take) begin
                        // setup cycle: select up, enable still low
                        ms_state_q                 <= MS_SETUP;
                        cmd_ready                  <= 1'h0;
                        out_port_select            <= 1'h1;
                        out_port_select_check      <= 1'h0;
                        out_port_activity          <= 1'h1;
                        out_port_activity_check    <= 1'h0;
                        out_port_direction         <= cmd_write;
                        out_port_direction_parity  <= ~cmd_write;
                        out_port_word_address      <= cmd_address;
                        out_port_address_parity    <= addr_par[`DALI_OUT_ADDR_MSB-`DALI_OUT_ADDR_LSB:0];
                        out_port_write_data        <= cmd_write_data;
                        out_port_write_data_parity <= odd_par32(cmd_write_data);
                    end
                end
                MS_SETUP: begin
                    ms_state_q            <= MS_ACCESS;
                    out_port_enable       <= 1'h1;
                    out_port_enable_check <= 1'h0;
                end
                MS_ACCESS: begin
                    // everything holds while the cluster slave stretches
                    if (out_port_ready) begin
                        ms_state_q              <= MS_IDLE;
                        out_port_select         <= 1'h0;
                        out_port_select_check   <= 1'h1;
                        out_port_enable         <= 1'h0;
                        out_port_enable_check   <= 1'h1;
                        out_port_activity       <= 1'h0;
                        out_port_activity_check <= 1'h1;
                        cmd_done                <= 1'h1;
                        cmd_error               <= out_port_error;
                        cmd_read_data           <= out_port_read_data;
                    end
                end
                default: begin
                    ms_state_q              <= MS_IDLE;
                    out_port_select         <= 1'h0;
                    out_port_select_check   <= 1'h1;
                    out_port_enable         <= 1'h0;
                    out_port_enable_check   <= 1'h1;
                    out_port_activity       <= 1'h0;
                    out_port_activity_check <= 1'h1;
                end
            endcase
        end
    end

endmodule

// *** verif/dali_link_monitor.sv ***
/*
 * Checker for the debug-unit APB link pair, bound to dali_link.
 * Assumes one clock and a synchronous active-high reset.
 */
module dali_link_monitor (
    // clock and reset
    input wire        clock,
    input wire        rst,
    // inbound link
    input wire        in_port_select,
    input wire        in_port_enable,
    input wire        in_port_ready,
    input wire        in_port_ready_check,
    input wire        in_port_error,
    input wire        in_port_error_check,
    input wire        in_resp_done,
    input wire        power_down_accepted,
    // outbound link
    input wire        out_port_select,
    input wire        out_port_select_check,
    input wire [19:2] out_port_word_address,
    input wire [19:2] out_port_address_parity,
    input wire        out_port_enable,
    input wire        out_port_enable_check,
    input wire        out_port_direction,
    input wire        out_port_direction_parity,
    input wire [31:0] out_port_write_data,
    input wire [31:0] out_port_write_data_parity,
    input wire        out_port_activity,
    input wire        out_port_activity_check,
    input wire        out_port_ready,
    input wire        out_port_error,
    input wire        cmd_valid,
    input wire        cmd_write,
    input wire        cmd_ready,
    input wire        cmd_done,
    input wire        cmd_error
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pd_q;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // power-down acceptance is sticky until reset
    always_ff @(posedge clock) pd_q <= rst ? 1'b0 : (pd_q | power_down_accepted);

    property p_inv_in; in_port_ready_check == !in_port_ready && in_port_error_check == !in_port_error; endproperty
    a_inv_in: assert property (p_inv_in) else $error("inbound check outputs not inverted");
    property p_inv_out;
        out_port_select_check == !out_port_select && out_port_enable_check == !out_port_enable
        && out_port_activity_check == !out_port_activity;
    endproperty
    a_inv_out: assert property (p_inv_out) else $error("outbound check outputs not inverted");
    property p_parity;
        out_port_address_parity == ~out_port_word_address && out_port_write_data_parity == ~out_port_write_data
        && out_port_direction_parity == !out_port_direction;
    endproperty
    a_parity: assert property (p_parity) else $error("outbound parity wrong");
    property p_dir; cmd_valid && cmd_ready |=> out_port_select && out_port_direction == $past(cmd_write); endproperty
    a_dir: assert property (p_dir) else $error("direction not taken from command");
    property p_rdy_cause; in_port_ready |-> $past(in_resp_done) || pd_q; endproperty
    a_rdy_cause: assert property (p_rdy_cause) else $error("inbound ready without completion");
    property p_hold;
        out_port_enable && !out_port_ready |=> out_port_enable && $stable(out_port_select)
        && $stable(out_port_word_address) && $stable(out_port_write_data);
    endproperty
    a_hold: assert property (p_hold) else $error("outbound request moved while stretched");
    property p_err_in; in_port_error |-> in_port_ready; endproperty
    a_err_in: assert property (p_err_in) else $error("inbound error outside completion");
    property p_done; out_port_enable && out_port_ready |=> cmd_done && cmd_error == $past(out_port_error); endproperty
    a_done: assert property (p_done) else $error("outbound completion not reported");
    property p_phase; $rose(out_port_select) |=> out_port_enable ##1 out_port_enable || !out_port_select; endproperty
    a_phase: assert property (p_phase) else $error("enable phase out of order");
    property p_pd; (pd_q || power_down_accepted) && in_port_select && !in_port_enable |=> in_port_ready && in_port_error; endproperty
    a_pd: assert property (p_pd) else $error("access after power-down not refused");
    c_wait: cover property (out_port_enable && !out_port_ready);
    c_fail: cover property (cmd_done && cmd_error);
    c_pd: cover property (pd_q && in_port_error);
endmodule

bind dali_link dali_link_monitor u_mon (.*);

// *** verif/dali_slave_model.sv ***
/*
 * Cluster APB slave facing the outbound port, with settable stretch and error.
 * Assumes the link's clock and reset.
 */
module dali_slave_model (
    // clock and reset
    input  wire         clock,
    input  wire         rst,
    // request from the link
    input  wire         out_port_select,
    input  wire         out_port_enable,
    input  wire         out_port_direction,
    input  wire  [19:2] out_port_word_address,
    input  wire  [31:0] out_port_write_data,
    // behaviour set by the bench
    input  wire  [3:0]  slv_wait,
    input  wire         slv_fail,
    // answer
    output logic        out_port_ready,
    output logic [31:0] out_port_read_data,
    output logic        out_port_error,
    output logic [31:0] slv_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0]  cnt_q;
    logic [31:0] idle_q;
    assign out_port_ready = out_port_select && out_port_enable && cnt_q == slv_wait;
    assign out_port_error = out_port_ready && slv_fail;
    // undriven data toggles so a stale value never looks valid
    assign out_port_read_data = out_port_ready ? {12'h000, out_port_word_address, 2'h0} ^ 32'h5a5a0000 : idle_q;
    always_ff @(posedge clock) begin
        idle_q <= rst ? 32'h0f0f0f0f : ~idle_q;
        cnt_q <= (rst || !out_port_enable || out_port_ready) ? 4'h0 : cnt_q + 4'h1;
        if (out_port_ready && out_port_direction) slv_wdata <= out_port_write_data;
    end
endmodule

// *** verif/tb_top.sv ***
/*
 * Self-checking bench for dali_link with the cluster slave model.
 * Assumes the design header is reachable by bare name.
 */
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin bad_count++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0, rst = 1'b1, in_port_select = 1'b0, in_port_enable = 1'b0, in_port_activity = 1'b0;
    logic [8:2] in_port_word_address = 7'h00, in_req_address;
    logic [8:0] in_port_write_data = 9'h000, in_req_write_data;
    logic in_port_ready, in_port_ready_check, in_port_error, in_port_error_check, in_req_valid, in_link_active;
    logic in_resp_done = 1'b0, in_resp_error = 1'b0, power_down_accepted = 1'b0, slv_fail = 1'b0;
    logic out_port_select, out_port_select_check, out_port_enable, out_port_enable_check, out_port_direction;
    logic out_port_direction_parity, out_port_activity, out_port_activity_check, out_port_ready, out_port_error;
    logic [19:2] out_port_word_address, out_port_address_parity, cmd_address = 18'h00000;
    logic [31:0] out_port_write_data, out_port_write_data_parity, out_port_read_data, cmd_read_data, slv_wdata;
    logic [31:0] cmd_write_data = 32'h00000000;
    logic cmd_valid = 1'b0, cmd_write = 1'b0, cmd_ready, cmd_done, cmd_error;
    logic [3:0] slv_wait = 4'h0;
    int bad_count = 0, cmp_count = 0, cyc = 0, n;

    dali_link u_dut (.*);
    dali_slave_model u_slv (.*);
    always #2.5 clock = ~clock;
    always @(posedge clock) begin
        cyc++;
        // whole run needs under a hundred cycles
        if (cyc == 2000) begin
            bad_count++;
            close_out();
        end
    end

    task automatic close_out();
        $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
        if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic out_cmd(input logic wr, input logic [19:2] a, input logic [31:0] d, input logic [3:0] w,
                           input logic f);
        n = 0;
        do begin @(posedge clock); n++; end while (cmd_ready !== 1'b1 && n < 20);
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        cmd_address <= a;
        cmd_write_data <= d;
        slv_wait <= w;
        slv_fail <= f;
        @(posedge clock);
        cmd_valid <= 1'b0;
        @(posedge clock);
        `CHK("direction", wr, out_port_direction)
        `CHK("setup enable", 1'b0, out_port_enable)
        `CHK("activity check", 1'b0, out_port_activity_check)
        `CHK("address parity", ~a, out_port_address_parity)
        if (wr) `CHK("data parity", ~d, out_port_write_data_parity)
        n = 0;
        do begin @(posedge clock); n++; end while (cmd_done !== 1'b1 && n < 20);
        `CHK("done delay", 32'(w) + 2, n)
        `CHK("select released", 1'b0, out_port_select)
        `CHK("command error", f, cmd_error)
        if (wr) `CHK("written data", d, slv_wdata)
        else `CHK("read data", {12'h000, a, 2'h0} ^ 32'h5a5a0000, cmd_read_data)
    endtask

    task automatic in_acc(input logic [8:2] a, input logic [8:0] d, input int w, input logic e, input logic pd);
        @(posedge clock);
        in_port_select <= 1'b1;
        in_port_activity <= 1'b1;
        in_port_word_address <= a;
        in_port_write_data <= d;
        @(posedge clock);
        in_port_enable <= 1'b1;
        if (!pd) begin
            @(posedge clock);
            `CHK("request pulse", 1'b1, in_req_valid)
            `CHK("request address", a, in_req_address)
            `CHK("request data", d, in_req_write_data)
            repeat (w) @(posedge clock);
            in_resp_done <= 1'b1;
            in_resp_error <= e;
            @(posedge clock);
            in_resp_done <= 1'b0;
            `CHK("ready held low", 1'b0, in_port_ready)
        end
        @(posedge clock);
        if (pd) `CHK("no request", 1'b0, in_req_valid)
        `CHK("ready", 1'b1, in_port_ready)
        `CHK("ready check", 1'b0, in_port_ready_check)
        `CHK("error", e | pd, in_port_error)
        `CHK("error check", ~(e | pd), in_port_error_check)
        `CHK("link active", 1'b1, in_link_active)
        in_port_select <= 1'b0;
        in_port_enable <= 1'b0;
        in_port_activity <= 1'b0;
        in_resp_error <= 1'b0;
    endtask

    task automatic sc_reset();
        @(posedge clock);
        `CHK("select check idle", 1'b1, out_port_select_check)
        `CHK("address parity idle", 18'h3ffff, out_port_address_parity)
        `CHK("ready check idle", 1'b1, in_port_ready_check)
        `CHK("link idle", 1'b0, in_link_active)
    endtask

    // reset in mid-run must clear the sticky power-down refusal
    task automatic sc_rerun();
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        in_acc(7'h33, 9'h0cc, 1, 1'b0, 1'b0);
        out_cmd(1'b0, 18'h0abcd, 32'h00000000, 4'h4, 1'b0);
    endtask

    task automatic sc_outbound();
        out_cmd(1'b1, 18'h3ffff, 32'hffff0000, 4'h0, 1'b0);
        out_cmd(1'b0, 18'h00001, 32'h00000000, 4'h3, 1'b0);
        out_cmd(1'b1, 18'h2aaaa, 32'h12345678, 4'h2, 1'b1);
        out_cmd(1'b0, 18'h15555, 32'h00000000, 4'h0, 1'b1);
    endtask

    task automatic sc_inbound();
        in_acc(7'h7f, 9'h1ff, 0, 1'b0, 1'b0);
        in_acc(7'h01, 9'h100, 3, 1'b1, 1'b0);
        @(posedge clock);
        power_down_accepted <= 1'b1;
        @(posedge clock);
        power_down_accepted <= 1'b0;
        in_acc(7'h2a, 9'h0a5, 0, 1'b0, 1'b1);
        in_acc(7'h55, 9'h15a, 0, 1'b0, 1'b1);
        out_cmd(1'b1, 18'h00100, 32'hcafe0001, 4'h1, 1'b0);
    endtask

    initial begin
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        sc_reset();
        sc_outbound();
        sc_inbound();
        sc_rerun();
        close_out();
    end
endmodule
